//--- shared/uart_pin_pkg.sv
// package: register offsets, field positions, reset values and carriers
package uart_pin_pkg;

  // ---------------------------------------------------------------
  // register offsets (own map)
  // ---------------------------------------------------------------
  localparam logic [2:0] INT_EN_ADDR = 3'h1;
  localparam logic [2:0] FEAT_CTL_ADDR = 3'h2;
  localparam logic [2:0] MDM_CTL_ADDR = 3'h4;
  localparam logic [2:0] MSR_ADDR = 3'h6;
  localparam logic [2:0] ENH_FEAT_ADDR = 3'h7;
  localparam logic [2:0] TXD_ADDR = 3'h0;
  localparam logic [2:0] STAT_ADDR = 3'h5;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ENH_DIR = 4;
  localparam int ENH_ARTS = 6;
  localparam int ENH_ACTS = 7;
  localparam int MDM_DTR = 0;
  localparam int MDM_RTS = 1;
  localparam int MDM_GPO = 2;
  localparam int MDM_IR = 6;
  localparam int FEAT_DIR = 3;
  localparam int INT_RTS = 6;
  localparam int INT_CTS = 7;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BIT_CYCLES = 4'hF;   // cycles per serial bit - 1
  localparam logic [3:0] FRAME_BITS = 4'h9;   // start + 8 data + stop - 1
  localparam logic [3:0] BREAK_BITS = 4'hA;   // bits away from idle = break
  localparam logic [2:0] RX_TRIG = 3'h4;      // rx level that drops rts

  // bus request carrier
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  // modem pins, all active low at the pins
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } modem_in_s;

endpackage

//--- src/uart_serial_modem_pin_control.sv
// pin-level serial, modem and mode-pin control of the uart
//
// Contract
// - tx idle high wired, low infrared
// - infrared from pin or software bit
// - flag break when rx leaves idle
// - auto rts gated by four register bits
// - auto rts needs rts asserted first
// - auto cts halts transmitter while deasserted
// - modem pins usable as general io
// - pc mode select enables address decode
// - printer decode in pc, else drive disable
// - output one general unless direction bit
// - direction pin low while transmitting
// - reset returns registers to defaults
// - direction high after last stop bit
// - direction needs both enable bits set
// - drive disable low during host read
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module uart_serial_modem_pin_control (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire uart_pin_pkg::bus_req_s bus_req,
  output logic [7:0] rdata,
  input wire logic infrared_enable_pin,
  input wire logic pc_mode_sel_n,
  input wire logic [9:3] host_addr,
  input wire logic host_read,
  input wire logic rx_pin,
  input wire uart_pin_pkg::modem_in_s modem_in,
  input wire logic [2:0] rx_level,
  output logic tx_pin,
  output logic rts_n,
  output logic dtr_n,
  output logic general_output_one_n,
  output logic printer_port2_decode_n,
  output logic bus_drive_disable_n,
  output logic com_decode
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three stages; a change counts only once stages two and three agree
  logic [4:0] s1_q, s2_q, s3_q, pin_q;
  logic [4:0] pin_d;
  logic [4:0] raw;
  assign raw = {rx_pin, modem_in};
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 5'h1F;
      s2_q <= 5'h1F;
      s3_q <= 5'h1F;
      pin_q <= 5'h1F;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end
  logic rx_s, cts_s;
  assign rx_s = pin_q[4];
  assign cts_s = pin_q[3];

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] int_en_q, feat_ctl_q, mdm_ctl_q, enh_feat_q;
  logic [7:0] int_en_d, feat_ctl_d, mdm_ctl_d, enh_feat_d;
  logic [7:0] txd_q, txd_d;
  logic load_q, load_d;
  logic break_q, break_d;
  logic [7:0] rdata_q, rdata_d;
  logic ir_mode;
  logic [3:0] st_bit_q, st_bit_d;
  logic tx_busy;
  assign ir_mode = infrared_enable_pin | mdm_ctl_q[uart_pin_pkg::MDM_IR];

  // writes update registers; status read clears break, set wins
  always_comb begin
    int_en_d = int_en_q;
    feat_ctl_d = feat_ctl_q;
    mdm_ctl_d = mdm_ctl_q;
    enh_feat_d = enh_feat_q;
    txd_d = txd_q;
    load_d = 1'b0;
    rdata_d = 8'h00;
    break_d = break_q;
    if (bus_req.wr) begin
      case (bus_req.addr)
        uart_pin_pkg::INT_EN_ADDR: int_en_d = bus_req.wdata;
        uart_pin_pkg::FEAT_CTL_ADDR: feat_ctl_d = bus_req.wdata;
        uart_pin_pkg::MDM_CTL_ADDR: mdm_ctl_d = bus_req.wdata;
        uart_pin_pkg::ENH_FEAT_ADDR: enh_feat_d = bus_req.wdata;
        uart_pin_pkg::TXD_ADDR: begin
          txd_d = bus_req.wdata;
          load_d = 1'b1;
        end
        default: ;
      endcase
    end
    if (bus_req.rd) begin
      case (bus_req.addr)
        uart_pin_pkg::INT_EN_ADDR: rdata_d = int_en_q;
        uart_pin_pkg::FEAT_CTL_ADDR: rdata_d = feat_ctl_q;
        uart_pin_pkg::MDM_CTL_ADDR: rdata_d = mdm_ctl_q;
        uart_pin_pkg::ENH_FEAT_ADDR: rdata_d = enh_feat_q;
        uart_pin_pkg::MSR_ADDR: rdata_d = {~pin_q[3:0], 4'h0};
        uart_pin_pkg::STAT_ADDR: begin
          rdata_d = {5'h00, ir_mode, tx_busy, break_q};
          break_d = 1'b0;
        end
        default: rdata_d = 8'h00;
      endcase
    end
    // break flag, rx away from idle level long enough
    if (st_bit_q == uart_pin_pkg::BREAK_BITS) begin
      break_d = 1'b1;
    end
  end
  // reset returns every register to default
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_en_q <= uart_pin_pkg::REG_RESET;
      feat_ctl_q <= uart_pin_pkg::REG_RESET;
      mdm_ctl_q <= uart_pin_pkg::REG_RESET;
      enh_feat_q <= uart_pin_pkg::REG_RESET;
      txd_q <= uart_pin_pkg::REG_RESET;
      load_q <= 1'b0;
      break_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      int_en_q <= int_en_d;
      feat_ctl_q <= feat_ctl_d;
      mdm_ctl_q <= mdm_ctl_d;
      enh_feat_q <= enh_feat_d;
      txd_q <= txd_d;
      load_q <= load_d;
      break_q <= break_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // break detector
  // ---------------------------------------------------------------
  // counts whole bit times with rx away from its mode idle level;
  // the partner is trusted to idle the line, so this only flags faults
  logic [3:0] st_cyc_q, st_cyc_d;
  logic rx_away;
  assign rx_away = ir_mode ? rx_s : ~rx_s;
  always_comb begin
    st_cyc_d = st_cyc_q;
    st_bit_d = st_bit_q;
    if (!rx_away) begin
      st_cyc_d = 4'h0;
      st_bit_d = 4'h0;
    end else if (st_bit_q != uart_pin_pkg::BREAK_BITS) begin
      st_cyc_d = st_cyc_q + 4'h1;
      if (st_cyc_q == uart_pin_pkg::BIT_CYCLES) begin
        st_bit_d = st_bit_q + 4'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_cyc_q <= 4'h0;
      st_bit_q <= 4'h0;
    end else begin
      st_cyc_q <= st_cyc_d;
      st_bit_q <= st_bit_d;
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_HALT, TX_SHIFT} tx_state_e;
  tx_state_e tx_q, tx_d;
  logic [9:0] sh_q, sh_d;
  logic [3:0] cyc_q, cyc_d, bit_q, bit_d;
  logic pend_q, pend_d;
  logic cts_ok;
  // auto cts: halt while cts deasserted
  assign cts_ok = !(enh_feat_q[uart_pin_pkg::ENH_ACTS]
                    && int_en_q[uart_pin_pkg::INT_CTS]) || !cts_s;
  assign tx_busy = (tx_q != TX_IDLE) | pend_q;
  always_comb begin
    tx_d = tx_q;
    sh_d = sh_q;
    cyc_d = cyc_q;
    bit_d = bit_q;
    pend_d = pend_q | load_q;
    case (tx_q)
      TX_IDLE: if (pend_q) begin
        tx_d = TX_HALT;
      end
      // waits at a frame boundary only, never mid-character
      TX_HALT: if (cts_ok) begin
        tx_d = TX_SHIFT;
        sh_d = {1'b1, txd_q, 1'b0};
        pend_d = load_q;
        cyc_d = 4'h0;
        bit_d = 4'h0;
      end
      TX_SHIFT: begin
        cyc_d = cyc_q + 4'h1;
        if (cyc_q == uart_pin_pkg::BIT_CYCLES) begin
          sh_d = {1'b1, sh_q[9:1]};
          bit_d = bit_q + 4'h1;
          if (bit_q == uart_pin_pkg::FRAME_BITS) begin
            tx_d = TX_IDLE;
          end
        end
      end
      default: tx_d = TX_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_q <= TX_IDLE;
      sh_q <= 10'h3FF;
      cyc_q <= 4'h0;
      bit_q <= 4'h0;
      pend_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      sh_q <= sh_d;
      cyc_q <= cyc_d;
      bit_q <= bit_d;
      pend_q <= pend_d;
    end
  end

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  logic tx_d2, rts_d, dtr_d, gpo_d, printer_port2_decode_n_d, drv_dis_d, com_d;
  logic arts_en_q, arts_en_d, dir_en;
  always_comb begin
    // line bit inverted in infrared mode
    tx_d2 = ((tx_q == TX_SHIFT) ? sh_q[0] : 1'b1) ^ ir_mode;
    // auto rts armed once rts bit set
    arts_en_d = arts_en_q;
    if (!mdm_ctl_q[uart_pin_pkg::MDM_RTS]) begin
      arts_en_d = 1'b0;
    end else if (enh_feat_q[uart_pin_pkg::ENH_ARTS]
                 && int_en_q[uart_pin_pkg::INT_RTS]) begin
      arts_en_d = 1'b1;
    end
    // rts and dtr plain outputs from control bits
    rts_d = ~mdm_ctl_q[uart_pin_pkg::MDM_RTS];
    dtr_d = ~mdm_ctl_q[uart_pin_pkg::MDM_DTR];
    // auto rts follows rx level vs trigger
    if (arts_en_q && feat_ctl_q[1:0] != 2'b00) begin
      rts_d = (rx_level >= uart_pin_pkg::RX_TRIG);
    end
    // direction only with both enable bits
    dir_en = enh_feat_q[uart_pin_pkg::ENH_DIR]
             & feat_ctl_q[uart_pin_pkg::FEAT_DIR];
    // low while busy, high after stop bit
    gpo_d = dir_en ? ~tx_busy : ~mdm_ctl_q[uart_pin_pkg::MDM_GPO];
    // pc mode decode of serial port range
    com_d = ~pc_mode_sel_n
            & ((host_addr == 7'h7F) | (host_addr == 7'h5F));
    // printer port 2 decode in pc mode
    printer_port2_decode_n_d = ~(host_addr == 7'h4F);
    // drive disable low during host read; in pc mode it follows printer decode
    drv_dis_d = ~host_read;
    if (!pc_mode_sel_n) begin
      drv_dis_d = printer_port2_decode_n_d;
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_pin <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      general_output_one_n <= 1'b1;
      printer_port2_decode_n <= 1'b1;
      bus_drive_disable_n <= 1'b1;
      com_decode <= 1'b0;
      arts_en_q <= 1'b0;
    end else begin
      tx_pin <= tx_d2;
      rts_n <= rts_d;
      dtr_n <= dtr_d;
      general_output_one_n <= gpo_d;
      printer_port2_decode_n <= ~pc_mode_sel_n ? printer_port2_decode_n_d : 1'b1;
      bus_drive_disable_n <= drv_dis_d;
      com_decode <= com_d;
      arts_en_q <= arts_en_d;
    end
  end
  assign rdata = rdata_q;

endmodule // uart_serial_modem_pin_control

//--- bench/uart_line_partner.sv
// partner: line transceiver and modem holding rx and modem inputs
`timescale 1ns/1ps
module uart_line_partner (
  input wire logic ir_mode,
  input wire logic hold_break,
  input wire uart_pin_pkg::modem_in_s modem_set,
  output logic rx_pin,
  output uart_pin_pkg::modem_in_s modem_in
);
  // ------------------------------
  // line levels
  // ------------------------------
  // idle per mode
  assign rx_pin = hold_break ? ir_mode : !ir_mode;
  // modem lines as commanded, no skew modelled
  assign modem_in = modem_set;
endmodule // uart_line_partner

//--- bench/uart_pin_properties.sv
// checker: port relations of the serial and mode-pin block
`timescale 1ns/1ps
module uart_pin_properties (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire uart_pin_pkg::bus_req_s bus_req,
  input wire logic [7:0] rdata,
  input wire logic pc_mode_sel_n,
  input wire logic [9:3] host_addr,
  input wire logic host_read,
  input wire logic tx_pin,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic printer_port2_decode_n,
  input wire logic bus_drive_disable_n,
  input wire logic com_decode
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // reset itself must be watched, so no disable here
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |->
    tx_pin && rts_n && dtr_n && !com_decode) else $error("reset levels");
  a_rdata_quiet: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("rdata outside read");
  a_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 3'h3
    |=> rdata == 8'h00) else $error("unmapped read");
  a_dtr_follow: assert property (bus_req.wr && bus_req.wdata[0] &&
    bus_req.addr == uart_pin_pkg::MDM_CTL_ADDR |-> ##[1:3] !dtr_n)
    else $error("dtr not driven");
  a_com_decode: assert property (!pc_mode_sel_n &&
    host_addr inside {7'h7F, 7'h5F} |=> com_decode) else $error("com");
  a_lpt_decode: assert property (!pc_mode_sel_n &&
    host_addr == 7'h4F |=> !printer_port2_decode_n) else $error("lpt");
  a_bus_mode_quiet: assert property (pc_mode_sel_n |=>
    printer_port2_decode_n && !com_decode) else $error("decode in bus mode");
  a_drvdis_read: assert property (pc_mode_sel_n && host_read
    |=> !bus_drive_disable_n) else $error("drive disable on read");
  a_drvdis_pc: assert property (!pc_mode_sel_n [*2] |->
    bus_drive_disable_n == printer_port2_decode_n)
    else $error("drive disable in pc mode");
endmodule // uart_pin_properties

bind uart_serial_modem_pin_control uart_pin_properties i_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req), .rdata(rdata),
  .pc_mode_sel_n(pc_mode_sel_n), .host_addr(host_addr),
  .host_read(host_read), .tx_pin(tx_pin), .rts_n(rts_n), .dtr_n(dtr_n),
  .printer_port2_decode_n(printer_port2_decode_n),
  .bus_drive_disable_n(bus_drive_disable_n), .com_decode(com_decode));

//--- bench/tb_uart_serial_modem_pin_control.sv
// testbench: register, serial line and mode-pin scenarios
`timescale 1ns/1ps
module tb_uart_serial_modem_pin_control;
  logic sys_clk, sys_rst, infrared_enable_pin, pc_mode_sel_n, host_read;
  logic ir_line, hold_break, rx_pin, tx_pin, rts_n, dtr_n, gpo_n;
  logic lpt_n, drv_n, com;
  logic [9:3] host_addr;
  logic [2:0] rx_level;
  logic [7:0] rdata;
  uart_pin_pkg::bus_req_s bus_req;
  uart_pin_pkg::modem_in_s modem_set, modem_in;
  int n_errors = 0;
  int samples_checked = 0;
  logic [2:0] regs [4] = '{3'h1, 3'h2, 3'h4, 3'h7};
  logic [3:0] pats [2] = '{4'h5, 4'hA};
  logic [2:0] lv [4] = '{3'h4, 3'h3, 3'h7, 3'h0};
  logic [9:3] da [4] = '{7'h7F, 7'h5F, 7'h4F, 7'h10};
  logic [1:0] de [4] = '{2'b11, 2'b11, 2'b00, 2'b01};

  uart_serial_modem_pin_control i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .rdata(rdata),
    .infrared_enable_pin(infrared_enable_pin), .pc_mode_sel_n(pc_mode_sel_n),
    .host_addr(host_addr), .host_read(host_read), .rx_pin(rx_pin),
    .modem_in(modem_in), .rx_level(rx_level), .tx_pin(tx_pin),
    .rts_n(rts_n), .dtr_n(dtr_n), .general_output_one_n(gpo_n),
    .printer_port2_decode_n(lpt_n), .bus_drive_disable_n(drv_n),
    .com_decode(com));
  uart_line_partner i_line (.ir_mode(ir_line), .hold_break(hold_break),
    .modem_set(modem_set), .rx_pin(rx_pin), .modem_in(modem_in));

  // ------------------------------
  // helpers
  // ------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // strobes last one cycle, released on the next edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus_req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m,
      input logic [7:0] e);
    @(posedge sys_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req <= '0;
    tick(1);
    cmp(rdata & m, e);
  endtask
  // samples each bit at its middle; ir flips every level
  task automatic frame(input logic [7:0] d, input logic ir, input logic dir);
    int i;
    i = 0;
    while (tx_pin !== ir && i < 100) begin
      tick(1);
      i++;
    end
    tick(8);
    cmp({7'h0, tx_pin}, {7'h0, ir});
    cmp({7'h0, gpo_n}, {7'h0, dir});
    for (i = 0; i < 9; i++) begin
      tick(16);
      cmp({7'h0, tx_pin}, {7'h0, i < 8 ? d[i] ^ ir : !ir});
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard, well past the 1200 or so cycles needed
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    print_verdict;
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    {sys_rst, infrared_enable_pin, pc_mode_sel_n, host_read} = 4'b1010;
    {ir_line, hold_break} = 2'b00;
    bus_req = '0;
    host_addr = '0;
    rx_level = '0;
    modem_set = 4'hF;
    repeat (10) @(posedge sys_clk);
    cmp({1'b0, dtr_n, rts_n, gpo_n, lpt_n, drv_n, tx_pin, com}, 8'h7E);
    sys_rst <= 1'b0;
    foreach (regs[k]) rd(regs[k], 8'hFF, 8'h00);
    wr(3'h3, 8'hFF);
    rd(3'h3, 8'hFF, 8'h00);
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h07);
    tick(3);
    cmp({5'h0, dtr_n, rts_n, gpo_n}, 8'h00);
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h00);
    tick(3);
    cmp({5'h0, dtr_n, rts_n, gpo_n}, 8'h07);
    foreach (pats[k]) begin
      @(posedge sys_clk) modem_set <= pats[k];
      tick(6);
      rd(uart_pin_pkg::MSR_ADDR, 8'hF0, {~pats[k], 4'h0});
    end
    wr(uart_pin_pkg::INT_EN_ADDR, 8'h40);
    wr(uart_pin_pkg::ENH_FEAT_ADDR, 8'h40);
    wr(uart_pin_pkg::FEAT_CTL_ADDR, 8'h01);
    tick(3);
    cmp({7'h0, rts_n}, 8'h01);
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h02);
    foreach (lv[k]) begin
      @(posedge sys_clk) rx_level <= lv[k];
      tick(3);
      cmp({7'h0, rts_n}, {7'h0, lv[k] >= 3'h4});
    end
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h00);
    wr(uart_pin_pkg::FEAT_CTL_ADDR, 8'h08);
    wr(uart_pin_pkg::ENH_FEAT_ADDR, 8'h00);
    wr(uart_pin_pkg::TXD_ADDR, 8'h5A);
    frame(8'h5A, 1'b0, 1'b1);
    wr(uart_pin_pkg::ENH_FEAT_ADDR, 8'h10);
    wr(uart_pin_pkg::TXD_ADDR, 8'hA5);
    frame(8'hA5, 1'b0, 1'b0);
    tick(24);
    cmp({7'h0, gpo_n}, 8'h01);
    wr(uart_pin_pkg::ENH_FEAT_ADDR, 8'h80);
    wr(uart_pin_pkg::INT_EN_ADDR, 8'h80);
    @(posedge sys_clk) modem_set <= 4'hF;
    tick(6);
    wr(uart_pin_pkg::TXD_ADDR, 8'h96);
    tick(40);
    cmp({7'h0, tx_pin}, 8'h01);
    @(posedge sys_clk) modem_set <= 4'h7;
    frame(8'h96, 1'b0, 1'b1);
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h40);
    @(posedge sys_clk) ir_line <= 1'b1;
    tick(4);
    cmp({7'h0, tx_pin}, 8'h00);
    wr(uart_pin_pkg::TXD_ADDR, 8'h3C);
    frame(8'h3C, 1'b1, 1'b1);
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h00);
    @(posedge sys_clk) infrared_enable_pin <= 1'b1;
    wr(uart_pin_pkg::TXD_ADDR, 8'hC3);
    frame(8'hC3, 1'b1, 1'b1);
    @(posedge sys_clk) {infrared_enable_pin, ir_line} <= 2'b00;
    @(posedge sys_clk) hold_break <= 1'b1;
    tick(200);
    rd(uart_pin_pkg::STAT_ADDR, 8'h01, 8'h01);
    @(posedge sys_clk) hold_break <= 1'b0;
    tick(6);
    // flag is sticky: set again while break was still held after clear
    rd(uart_pin_pkg::STAT_ADDR, 8'h01, 8'h01);
    rd(uart_pin_pkg::STAT_ADDR, 8'h01, 8'h00);
    wr(uart_pin_pkg::MDM_CTL_ADDR, 8'h07);
    @(posedge sys_clk) sys_rst <= 1'b1;
    @(posedge sys_clk) sys_rst <= 1'b0;
    rd(uart_pin_pkg::MDM_CTL_ADDR, 8'hFF, 8'h00);
    foreach (da[k]) begin
      @(posedge sys_clk) {pc_mode_sel_n, host_addr} <= {1'b0, da[k]};
      tick(2);
      cmp({5'h0, drv_n, com, lpt_n}, {5'h0, de[k][0], de[k]});
    end
    @(posedge sys_clk) {pc_mode_sel_n, host_read} <= 2'b11;
    tick(2);
    cmp({6'h0, drv_n, com}, 8'h00);
    @(posedge sys_clk) host_read <= 1'b0;
    tick(2);
    cmp({7'h0, drv_n}, 8'h01);
    print_verdict;
  end
endmodule // tb_uart_serial_modem_pin_control
